// [sysctl_pkg.sv]
// Package of offsets, field positions and reset values for the system control word
package sysctl_pkg;
  // ----------------------------------------------------------------
  // Register location and access space
  // ----------------------------------------------------------------
  localparam logic [11:0] SCW_OFFSET = 12'h00F4;
  localparam logic [2:0] SUPER_DATA_FC = 3'h5;
  localparam logic [2:0] FC_RESERVED = 3'h7;
  // ----------------------------------------------------------------
  // Field positions in the system control word
  // ----------------------------------------------------------------
  localparam int IPA_BIT = 31;
  localparam int HWT_BIT = 30;
  localparam int WPV_BIT = 29;
  localparam int ADC_BIT = 28;
  localparam int WRITE_PROTECT_VIOLATION_ENABLE_BIT = 20;
  localparam int LOCKED_CYCLE_TREATMENT_BIT = 19;
  localparam int EXTERNAL_MASTER_WAIT_BIT = 18;
  localparam int DECODE_CONFLICT_ENABLE_BIT = 17;
  localparam int BUS_CLEAR_MASK_BIT = 16;
  localparam int SAM_BIT = 12;
  // ----------------------------------------------------------------
  // Reset values, control write mask and external-acknowledge wait code
  // ----------------------------------------------------------------
  localparam logic [3:0] FLAGS_RESET = 4'h0;
  localparam logic [31:0] CTRL_RESET = 32'h0000_0000;
  localparam logic [31:0] CTRL_MASK = 32'h00FF_FFFF;
  localparam logic [2:0] WAIT_EXTERNAL = 3'h7;
endpackage

// [cs_prio.sv]
// Fixed-priority chip-select resolver with conflict detection
`timescale 1ns/1ps
module cs_prio #(
  parameter int N = 4
) (
  input wire logic [N-1:0] match,
  output logic [N-1:0] grant,
  output logic conflict
);
  // ----------------------------------------------------------------
  // Lowest index wins; never more than one line granted
  // ----------------------------------------------------------------
  always_comb begin
    grant = '0;
    for (int i = N - 1; i >= 0; i--) begin
      if (match[i]) begin
        grant = '0;
        grant[i] = 1'b1;
      end
    end
  end

  // Two or more simultaneous matches
  assign conflict = (match & (match - 1'b1)) != '0;
endmodule // cs_prio

// [system_control_status_logic.sv]
// System control word: event flags, bus error, locked-cycle and wait control
`timescale 1ns/1ps
module system_control_status_logic #(
  parameter int NCS = 4
) (
  input wire logic CLK,
  input wire logic RESETN,
  input wire logic HALTN,
  input wire logic BUS_CYCLE,
  input wire logic [23:0] ADDR,
  input wire logic [2:0] FC,
  input wire logic RW_WRITE,
  input wire logic EXT_MASTER,
  input wire logic [31:0] WDATA,
  output logic [31:0] RDATA,
  input wire logic [NCS-1:0] CS_MATCH,
  input wire logic [NCS-1:0] REGION_RW,
  input wire logic [NCS-1:0] READ_WRITE_MASK,
  input wire logic [NCS-1:0][2:0] REGION_WAITS,
  output logic [NCS-1:0] CS_ASSERT,
  output logic AS_ASSERT,
  input wire logic CONFIG_ACCESS,
  input wire logic IRQ_UNMASKED,
  input wire logic WATCHDOG_EXPIRED,
  input wire logic LOCKED_CYCLE_SIGNAL,
  input wire logic LOCKED_WRITE_PHASE,
  input wire logic LOCKED_PHASE_GAP,
  input wire logic BUS_REQUEST,
  output logic BUS_GRANT,
  output logic BUS_ERROR,
  output logic BUS_CLEAR_OUTPUT,
  output logic BLOCK_DMA_CLEAR,
  output logic [2:0] WAIT_STATES,
  output logic EXTERNAL_ACK
);
  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  logic irq_flag;
  logic wdt_flag;
  logic wpv_flag;
  logic adc_flag;
  logic [31:0] ctrl;
  logic scw_sel;
  logic scw_write;
  logic [NCS-1:0] cs_grant;
  logic cs_conflict;
  logic wp_event;
  logic adc_event;
  logic [31:0] clr;
  logic sys_reset;
  logic wpv_enable;
  logic adc_enable;
  logic rmc_treat;
  logic external_master_wait;
  logic bus_clear_mask;
  logic synchronous_access_mode;
  logic [2:0] base_waits;
  logic internal_access;

  // ----------------------------------------------------------------
  // Status assembly and bus error causes
  // ----------------------------------------------------------------
  logic [7:0] status;
  logic [31:0] next_rdata;
  logic wdt_berr;
  logic wpv_berr;
  logic adc_berr;

  // ----------------------------------------------------------------
  // Wait-state terms
  // ----------------------------------------------------------------
  logic sel_any;
  logic locked_write_free;
  logic ext_extra;
  logic sync_read_extra;
  logic [2:0] cs_waits;

  // One-of-many check used by both the violation and the wait logic
  function automatic logic any_granted(input logic [NCS-1:0] g, input logic [NCS-1:0] v);
    any_granted = (g & v) != '0;
  endfunction

  // Sticky flag update: a fresh event beats a clear in the same cycle
  function automatic logic next_flag(input logic set, input logic cur, input logic clear);
    next_flag = set || (cur && !clear);
  endfunction

  // ----------------------------------------------------------------
  // Address decode
  // ----------------------------------------------------------------
  assign scw_sel = BUS_CYCLE && (ADDR[11:0] == sysctl_pkg::SCW_OFFSET)
                   && (FC == sysctl_pkg::SUPER_DATA_FC);
  assign scw_write = scw_sel && RW_WRITE;
  assign sys_reset = !RESETN && !HALTN;


  // ----------------------------------------------------------------
  // Control field decode
  // ----------------------------------------------------------------
  // Violation bus error enable
  assign wpv_enable = ctrl[sysctl_pkg::WRITE_PROTECT_VIOLATION_ENABLE_BIT];
  // Conflict bus error enable
  assign adc_enable = ctrl[sysctl_pkg::DECODE_CONFLICT_ENABLE_BIT];
  // Locked-cycle special treatment
  assign rmc_treat = ctrl[sysctl_pkg::LOCKED_CYCLE_TREATMENT_BIT];
  // Extra wait for external masters
  assign external_master_wait = ctrl[sysctl_pkg::EXTERNAL_MASTER_WAIT_BIT];
  // Interrupt flag may clear the bus
  assign bus_clear_mask = ctrl[sysctl_pkg::BUS_CLEAR_MASK_BIT];
  // Synchronous access by external masters
  assign synchronous_access_mode = ctrl[sysctl_pkg::SAM_BIT];

  // ----------------------------------------------------------------
  // Chip-select priority and event detection
  // ----------------------------------------------------------------
  cs_prio #(
    .N(NCS)
  ) u_prio (
    .match(CS_MATCH & {NCS{FC != sysctl_pkg::FC_RESERVED}}),
    .grant(cs_grant),
    .conflict(cs_conflict)
  );

  // Read-only region with its read/write bit unmasked, written
  assign wp_event = BUS_CYCLE && RW_WRITE
                    && any_granted(cs_grant, ~REGION_RW & READ_WRITE_MASK);
  // Config register accesses must stay reachable during init
  assign adc_event = BUS_CYCLE && cs_conflict && !CONFIG_ACCESS && !scw_sel;

  // ----------------------------------------------------------------
  // Event flags: set wins over write-one clear
  // ----------------------------------------------------------------
  assign clr = scw_write ? WDATA : 32'h0000_0000;

  // Interrupt pending; a request still pending re-sets it at once
  always_ff @(posedge CLK) begin
    if (sys_reset) begin
      irq_flag <= sysctl_pkg::FLAGS_RESET[3];
    end else begin
      irq_flag <= next_flag(IRQ_UNMASKED, irq_flag, clr[sysctl_pkg::IPA_BIT]);
    end
  end

  // Watchdog timeout
  always_ff @(posedge CLK) begin
    if (sys_reset) begin
      wdt_flag <= sysctl_pkg::FLAGS_RESET[2];
    end else begin
      wdt_flag <= next_flag(WATCHDOG_EXPIRED, wdt_flag, clr[sysctl_pkg::HWT_BIT]);
    end
  end

  // Write-protect violation; sets whatever the enable says
  always_ff @(posedge CLK) begin
    if (sys_reset) begin
      wpv_flag <= sysctl_pkg::FLAGS_RESET[1];
    end else begin
      wpv_flag <= next_flag(wp_event, wpv_flag, clr[sysctl_pkg::WPV_BIT]);
    end
  end

  // Decode conflict; sets whatever the enable says
  always_ff @(posedge CLK) begin
    if (sys_reset) begin
      adc_flag <= sysctl_pkg::FLAGS_RESET[0];
    end else begin
      adc_flag <= next_flag(adc_event, adc_flag, clr[sysctl_pkg::ADC_BIT]);
    end
  end

  // ----------------------------------------------------------------
  // Control bits, all zero after reset
  // ----------------------------------------------------------------
  always_ff @(posedge CLK) begin
    if (!RESETN) begin
      ctrl <= sysctl_pkg::CTRL_RESET;
    end else if (scw_write) begin
      ctrl <= WDATA & sysctl_pkg::CTRL_MASK;
    end
  end

  // ----------------------------------------------------------------
  // Read data: flags in the top byte, readable any time
  // ----------------------------------------------------------------
  // Unused status bits always read zero
  assign status = {irq_flag, wdt_flag, wpv_flag, adc_flag, 4'h0};
  assign next_rdata = {status, ctrl[23:0]};

  // Registered so the bus sees a settled word one edge later
  always_ff @(posedge CLK) begin
    if (!RESETN) begin
      RDATA <= 32'h0000_0000;
    end else if (scw_sel && !RW_WRITE) begin
      RDATA <= next_rdata;
    end
  end

  // ----------------------------------------------------------------
  // Bus error: raised on the causing cycle, even if flag already set
  // ----------------------------------------------------------------
  // Watchdog error is unconditional
  assign wdt_berr = WATCHDOG_EXPIRED;
  // Flag state is not consulted, so a repeat still errors
  assign wpv_berr = wp_event && wpv_enable;
  assign adc_berr = adc_event && adc_enable;
  assign BUS_ERROR = wdt_berr || wpv_berr || adc_berr;

  // Bus clear from pending interrupt when masked in
  assign BUS_CLEAR_OUTPUT = irq_flag && bus_clear_mask;
  assign BLOCK_DMA_CLEAR = irq_flag && bus_clear_mask;

  // ----------------------------------------------------------------
  // Locked read-modify-write strobe and grant treatment
  // ----------------------------------------------------------------
  // Treatment one drops strobes between read and write parts
  assign AS_ASSERT = BUS_CYCLE && !(rmc_treat && LOCKED_CYCLE_SIGNAL && LOCKED_PHASE_GAP);
  assign CS_ASSERT = AS_ASSERT ? cs_grant : '0;
  // Grant withheld only under special treatment; plain mode grants freely
  assign BUS_GRANT = BUS_REQUEST && !(rmc_treat && LOCKED_CYCLE_SIGNAL);

  // ----------------------------------------------------------------
  // Wait-state count for the current cycle
  // ----------------------------------------------------------------
  always_comb begin
    base_waits = 3'h0;
    for (int i = 0; i < NCS; i++) begin
      if (cs_grant[i]) begin
        base_waits = REGION_WAITS[i];
      end
    end
  end

  // No line matched: the cycle targets internal peripherals
  assign internal_access = BUS_CYCLE && CS_MATCH == '0;
  assign sel_any = any_granted(cs_grant, {NCS{1'b1}});
  assign EXTERNAL_ACK = sel_any && (base_waits == sysctl_pkg::WAIT_EXTERNAL);

  // Plain treatment: locked write part runs with no waits
  assign locked_write_free = LOCKED_CYCLE_SIGNAL && LOCKED_WRITE_PHASE && !rmc_treat;
  // Saturates at six, since seven would mean external acknowledge
  assign ext_extra = EXT_MASTER && external_master_wait && (base_waits != 3'h6);
  // Synchronous internal reads only; internal writes never wait
  assign sync_read_extra = internal_access && EXT_MASTER && synchronous_access_mode && external_master_wait && !RW_WRITE;
  assign cs_waits = base_waits + {2'b00, ext_extra};

  always_comb begin
    WAIT_STATES = 3'h0;
    if (sel_any && !EXTERNAL_ACK) begin
      // Locked write part gets waits only with special treatment
      if (locked_write_free) begin
        WAIT_STATES = 3'h0;
      end else begin
        WAIT_STATES = cs_waits;
      end
    end else if (sync_read_extra) begin
      WAIT_STATES = 3'h1;
    end else begin
      WAIT_STATES = 3'h0;
    end
  end
endmodule // system_control_status_logic

// [sysctl_sva.sv]
// Port checker for the system control word
`timescale 1ns/1ps
module sysctl_sva #(
  parameter int NCS = 4
) (
  input wire logic CLK,
  input wire logic RESETN,
  input wire logic BUS_CYCLE,
  input wire logic [23:0] ADDR,
  input wire logic [2:0] FC,
  input wire logic RW_WRITE,
  input wire logic [31:0] WDATA,
  input wire logic [31:0] RDATA,
  input wire logic [NCS-1:0] CS_MATCH,
  input wire logic [NCS-1:0] CS_ASSERT,
  input wire logic IRQ_UNMASKED,
  input wire logic WATCHDOG_EXPIRED,
  input wire logic BUS_ERROR,
  input wire logic BUS_CLEAR_OUTPUT,
  input wire logic BLOCK_DMA_CLEAR
);
  logic hit, rd, wr, quiet, clr;
  logic [23:0] wd;
  // Word decode; quiet means no event cause can race a clear
  assign hit = BUS_CYCLE && ADDR[11:0] == 12'h0F4 && FC == 3'h5;
  assign rd = hit && !RW_WRITE;
  assign wr = hit && RW_WRITE;
  assign quiet = !IRQ_UNMASKED && !WATCHDOG_EXPIRED && CS_MATCH == '0;
  assign clr = wr && WDATA[31:28] == 4'hF && quiet;
  // Last control bits written
  always_ff @(posedge CLK) if (wr) wd <= WDATA[23:0];
  default clocking cb @(posedge CLK); endclocking
  default disable iff (!RESETN);
  // Flags show only through a read, so the flag checks pair a cause with a read
  a_wdog_berr: assert property (WATCHDOG_EXPIRED |-> BUS_ERROR) else $error("no berr");
  a_wdog_flag: assert property (WATCHDOG_EXPIRED ##1 rd |=> RDATA[30]) else $error("no hwt");
  a_irq_flag: assert property (IRQ_UNMASKED ##1 rd |=> RDATA[31]) else $error("no ipa");
  a_clear_pair: assert property (BUS_CLEAR_OUTPUT == BLOCK_DMA_CLEAR) else $error("bus_clear_output");
  a_cs_single: assert property ($onehot0(CS_ASSERT)) else $error("two selects");
  a_fc_block: assert property (FC == 3'h7 |-> CS_ASSERT == '0) else $error("fc7 select");
  a_ctrl_back: assert property (wr ##1 rd |=> RDATA[23:0] == wd) else $error("ctrl");
  a_clr_all: assert property (clr ##1 rd && quiet |=> RDATA[31:28] == 4'h0) else $error("clr");
  // Main scenarios reached
  c_clear_read: cover property (wr ##1 rd);
  c_timeout: cover property (WATCHDOG_EXPIRED);
  c_conflict: cover property (BUS_CYCLE && $countones(CS_MATCH) > 1);
endmodule // sysctl_sva

// [sysctl_master.sv]
// Bus master model issuing one held bus cycle at a time
`timescale 1ns/1ps
module sysctl_master (
  input wire logic CLK,
  output logic BUS_CYCLE,
  output logic [23:0] ADDR,
  output logic [2:0] FC,
  output logic RW_WRITE,
  output logic EXT_MASTER,
  output logic [31:0] WDATA
);
  // Idle until the first request
  initial begin
    {BUS_CYCLE, ADDR, FC, RW_WRITE, EXT_MASTER, WDATA} = '0;
  end
  // Launched at a falling edge, held across the taking edge; left up so
  // back-to-back cycles never toggle the strobe twice in one step
  task automatic cyc(input bit w, input logic [11:0] a, input logic [2:0] f, input logic [31:0] d);
    {ADDR, FC, WDATA} = {12'h000, a, f, d};
    {BUS_CYCLE, RW_WRITE, EXT_MASTER} = {1'b1, w, 1'($urandom)};
    @(negedge CLK);
  endtask
endmodule // sysctl_master

// [tb.sv]
// Bench comparing the system control word with a flag model
`timescale 1ns/1ps
`define CHK(n, e, g) begin check_count++; if ((g) !== (e)) begin err_total++; \
  $display("BAD %s exp %h got %h", n, e, g); end end
module tb;
  logic CLK, RESETN, HALTN, IRQ_UNMASKED, WATCHDOG_EXPIRED, CONFIG_ACCESS, be;
  logic BUS_CYCLE, RW_WRITE, EXT_MASTER, BUS_ERROR, BUS_CLEAR_OUTPUT;
  logic [23:0] ADDR, mc;
  logic [2:0] FC;
  logic [31:0] WDATA, RDATA;
  logic [3:0] CS_MATCH, REGION_RW, READ_WRITE_MASK, mf;
  logic [11:0] rwait;
  logic [2:0] WAIT_STATES, ws;
  logic EXTERNAL_ACK, BUS_REQUEST, BUS_GRANT;
  int check_count = 0, err_total = 0, cyc_n = 0, en, k;
  sysctl_master i_sysctl_master (.CLK, .BUS_CYCLE, .ADDR, .FC, .RW_WRITE, .EXT_MASTER, .WDATA);
  system_control_status_logic #(.NCS(4)) i_system_control_status_logic (.CLK, .RESETN, .HALTN,
    .BUS_CYCLE, .ADDR, .FC, .RW_WRITE, .EXT_MASTER, .WDATA, .RDATA, .CS_MATCH, .REGION_RW,
    .READ_WRITE_MASK, .REGION_WAITS(rwait), .CS_ASSERT(), .AS_ASSERT(), .CONFIG_ACCESS,
    .IRQ_UNMASKED, .WATCHDOG_EXPIRED, .LOCKED_CYCLE_SIGNAL(1'b0), .LOCKED_WRITE_PHASE(1'b0),
    .LOCKED_PHASE_GAP(1'b0), .BUS_REQUEST, .BUS_GRANT, .BUS_ERROR, .BUS_CLEAR_OUTPUT,
    .BLOCK_DMA_CLEAR(), .WAIT_STATES, .EXTERNAL_ACK);
  // 50 MHz clock
  initial begin
    CLK = 0;
    forever #10 CLK = ~CLK;
  end
  // Bus error is a same-cycle pulse, so catch it at the edge; cycle limit
  always @(posedge CLK) begin
    be <= BUS_ERROR;
    cyc_n++;
    if (cyc_n == 3000) begin
      err_total++;
      close_out();
    end
  end
  task automatic close_out();
    $display("checks %0d mismatches %0d", check_count, err_total);
    if (err_total == 0 && check_count > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  // Halt high keeps the flags: only the paired reset clears them
  task automatic rst(input bit h);
    {RESETN, HALTN} = {1'b0, h};
    repeat (3) @(negedge CLK);
    {RESETN, HALTN} = 2'b11;
    mc = '0;
    if (!h) mf = '0;
  endtask
  task automatic wr(input logic [31:0] d, input logic [2:0] f);
    i_sysctl_master.cyc(1, 12'h0F4, f, d);
    if (f == 3'h5) {mf, mc} = {mf & ~d[31:28], d[23:0]};
  endtask
  task automatic rd();
    i_sysctl_master.cyc(0, 12'h0F4, 3'h5, 32'h0000_0000);
    `CHK("rdata", {mf, 4'h0, mc}, RDATA)
  endtask
  // Events with enables off then on, each flag read and cleared
  initial begin
    void'($urandom(58997));
    {IRQ_UNMASKED, WATCHDOG_EXPIRED, CONFIG_ACCESS, CS_MATCH, REGION_RW, READ_WRITE_MASK} = '0;
    {rwait, BUS_REQUEST} = '0;
    {mf, mc} = '0;
    rst(0);
    for (en = 0; en < 2; en++) begin
      for (k = 0; k < 6; k++) begin
        wr({8'h00, 3'($urandom), en[0], 2'($urandom), en[0], 17'($urandom)}, 3'h5);
        {IRQ_UNMASKED, WATCHDOG_EXPIRED, CONFIG_ACCESS} = {k == 0, k == 1, k == 4};
        CS_MATCH = (k == 2 || k == 5) ? 4'h1 : (k > 2) ? 4'h3 : 4'h0;
        {REGION_RW, READ_WRITE_MASK} = {3'($urandom), 1'b0, 4'(k != 5)};
        {rwait, BUS_REQUEST} = {12'($urandom), 1'($urandom)};
        i_sysctl_master.cyc(k == 2 || k == 5, 12'h100, 3'h1, $urandom);
        // Wait count from the programmed field plus the external-master extra
        ws = rwait[2:0] + 3'(EXT_MASTER && mc[18] && rwait[2:0] != 3'h6);
        if (CS_MATCH == 4'h0) ws = 3'(EXT_MASTER && mc[12] && mc[18] && k < 2);
        else if (rwait[2:0] == 3'h7) ws = 3'h0;
        `CHK("waits", ws, WAIT_STATES)
        `CHK("xack", CS_MATCH != 4'h0 && rwait[2:0] == 3'h7, EXTERNAL_ACK)
        `CHK("grant", BUS_REQUEST, BUS_GRANT)
        {IRQ_UNMASKED, WATCHDOG_EXPIRED, CONFIG_ACCESS, CS_MATCH} = '0;
        `CHK("berr", k == 1 || (en == 1 && (k == 2 || k == 3)), be)
        if (k < 4) mf[3 - k] = 1'b1;
        rd();
        `CHK("bus_clear_output", mf[3] & mc[16], BUS_CLEAR_OUTPUT)
        {IRQ_UNMASKED, WATCHDOG_EXPIRED} = {en == 1 && k == 0, en == 1 && k == 1};
        wr({4'h8 >> k, 4'h0, mc}, 3'h5);
        if (en == 1 && k < 2) mf[3 - k] = 1'b1;
        {IRQ_UNMASKED, WATCHDOG_EXPIRED} = '0;
        rd();
      end
    end
    $display("events done");
    rst(1);
    rd();
    rst(0);
    rd();
    $display("reset done");
    wr(32'hF000_0000, 3'h5);
    rd();
    wr($urandom, 3'h7);
    rd();
    $display("access done");
    close_out();
  end
endmodule // tb
bind system_control_status_logic sysctl_sva #(.NCS(NCS)) i_sysctl_sva (.CLK, .RESETN,
  .BUS_CYCLE, .ADDR, .FC, .RW_WRITE, .WDATA, .RDATA, .CS_MATCH, .CS_ASSERT, .IRQ_UNMASKED,
  .WATCHDOG_EXPIRED, .BUS_ERROR, .BUS_CLEAR_OUTPUT, .BLOCK_DMA_CLEAR);
